//--- hdl/param_guard_defines.svh
// Object indices, codes and reset values for the parameter store guard
// Summary of operation
// (R1) Life time is factor times guard time
// (R2) Factor zero switches node guarding off
// (R3) Guard time in ms; zero disables
// (R4) Sub-index zero reads highest sub-index 5
// (R5) Store sub-indices 1 to 4 valid
// (R6) Refuse store when enabled or quick stop
// (R7) Store only on exact save signature
// (R8) Confirm store only after store completes
// (R9) Failed store or restore aborts 06060000
// (R10) Wrong signature aborts 08000002, no action
// (R11) Save refused without DC-link supply
// (R12) Master resets drive after store
// (R13) Store read: bit0 command, bit1 auto
// (R14) Restore only sub-index 1 available
// (R15) Restore delivered or last saved set
// (R16) Restore only on exact load signature
// (R17) Expedited frame layout, 0x60 success reply
// (R18) Restored values active after NMT reset
// (R19) Restore read: bit0 restore capability
// (R20) Master resets drive after restore
// (R21) Report capabilities; abort unavailable sub-indices; uploads of unavailable sub-indices up to 5 reply 0 instead
// (R22) One store or restore at a time
`ifndef PARAM_GUARD_DEFINES_SVH
`define PARAM_GUARD_DEFINES_SVH
`define IDX_LIFE        16'h100d
`define IDX_STORE       16'h1010
`define IDX_RESTORE     16'h1011
`define CMD_DOWNLOAD    8'h23
`define CMD_UPLOAD      8'h40
`define RSP_DOWNLOAD    8'h60
`define RSP_UPLOAD_1B   8'h4f
`define RSP_UPLOAD_4B   8'h43
`define RSP_ABORT       8'h80
`define SIG_SAVE        32'h65766173
`define SIG_LOAD        32'h64616f6c
`define ABORT_FAIL      32'h06060000
`define ABORT_SIG       32'h08000002
`define ABORT_REFUSED   32'h08000022
`define ABORT_NOSUB     32'h06090011
`define ABORT_NOOBJ     32'h06020000
`define ABORT_BADCMD    32'h05040001
`define SUB_HIGHEST     8'h05
`define SUB_LAST_STORE  8'h04
`define CAP_STORE       32'h00000001
`define CAP_RESTORE     32'h00000001
`define FACTOR_RESET    8'h00
`endif

//--- hdl/param_guard_pkg.sv
// Types shared by the parameter store guard
package param_guard_pkg;
    typedef struct packed {
        logic [31:0] data;
        logic [7:0]  sub;
        logic [15:0] index;
        logic [7:0]  cmd;
    } sdo_frame_s;

    typedef struct packed {
        logic       restore;
        logic       from_saved;
        logic [7:0] sub;
    } nvm_cmd_s;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_wait  = 2'b01,
        st_reply = 2'b11
    } guard_state_e;
endpackage

//--- hdl/param_store_restore_guard.sv
// SDO command interpreter for life time factor, store and restore entries
`include "param_guard_defines.svh"
module param_store_restore_guard (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire param_guard_pkg::sdo_frame_s rx_frame,
    input  wire logic                     rx_valid,
    output logic                          rx_ready,
    output param_guard_pkg::sdo_frame_s   tx_frame,
    output logic                          tx_valid,
    input  wire logic                     tx_ready,
    input  wire logic [15:0]              guard_time,
    output logic [7:0]                    life_factor,
    output logic [23:0]                   life_time,
    output logic                          guarding_enabled,
    input  wire logic                     drive_op_enabled,
    input  wire logic                     drive_quick_stop,
    input  wire logic                     dc_link_present,
    input  wire logic                     use_saved_config,
    output logic                          nvm_req,
    output param_guard_pkg::nvm_cmd_s     nvm_cmd,
    input  wire logic                     nvm_done,
    input  wire logic                     nvm_fail,
    output logic                          warn_msg,
    output logic                          warn_store_refused,
    input  wire logic                     warn_clear,
    output logic                          reset_node_pending,
    output logic                          reset_comm_pending,
    input  wire logic                     nmt_reset_node,
    input  wire logic                     nmt_reset_comm
);
    import param_guard_pkg::*;

    guard_state_e state;
    guard_state_e next_state;
    sdo_frame_s   next_reply;
    sdo_frame_s   pend_hdr;
    logic         accept;
    logic         start_op;
    logic         refuse_state;
    logic         write_factor;
    logic         is_store;
    logic         sub_ok;
    logic [31:0]  sig;

    assign accept = rx_valid && rx_ready;

    // Decode of one request into a reply or an operation
    always_comb begin
        next_reply       = '0;
        next_reply.index = rx_frame.index;
        next_reply.sub   = rx_frame.sub;
        next_reply.cmd   = `RSP_ABORT;
        start_op         = 1'b0;
        refuse_state     = 1'b0;
        write_factor     = 1'b0;
        is_store         = (rx_frame.index == `IDX_STORE);
        sig              = is_store ? `SIG_SAVE : `SIG_LOAD;
        if (is_store) begin
            sub_ok = (rx_frame.sub >= 8'h01) && (rx_frame.sub <= `SUB_LAST_STORE); // R5
        end else begin
            sub_ok = (rx_frame.sub == 8'h01); // R14
        end
        case (rx_frame.cmd)
            `CMD_DOWNLOAD: begin
                if (rx_frame.index == `IDX_LIFE) begin
                    if (rx_frame.sub == 8'h00) begin
                        write_factor   = 1'b1;
                        next_reply.cmd = `RSP_DOWNLOAD; // R17
                    end else begin
                        next_reply.data = `ABORT_NOSUB;
                    end
                end else if (is_store || rx_frame.index == `IDX_RESTORE) begin
                    if (!sub_ok) begin
                        next_reply.data = `ABORT_NOSUB; // R21
                    end else if (rx_frame.data != sig) begin
                        next_reply.data = `ABORT_SIG; // R10
                    end else if (is_store && (drive_op_enabled || drive_quick_stop)) begin
                        refuse_state    = 1'b1; // R6
                        next_reply.data = `ABORT_REFUSED;
                    end else if (is_store && !dc_link_present) begin
                        next_reply.data = `ABORT_REFUSED; // R11
                    end else begin
                        start_op = 1'b1; // R7 R16
                    end
                end else begin
                    next_reply.data = `ABORT_NOOBJ;
                end
            end
            `CMD_UPLOAD: begin
                if (rx_frame.index == `IDX_LIFE && rx_frame.sub == 8'h00) begin
                    next_reply.cmd  = `RSP_UPLOAD_1B;
                    next_reply.data = {24'h000000, life_factor};
                end else if (is_store || rx_frame.index == `IDX_RESTORE) begin
                    if (rx_frame.sub == 8'h00) begin
                        next_reply.cmd  = `RSP_UPLOAD_1B;
                        next_reply.data = {24'h000000, `SUB_HIGHEST}; // R4
                    end else if (rx_frame.sub <= `SUB_HIGHEST) begin
                        next_reply.cmd = `RSP_UPLOAD_4B;
                        if (sub_ok) begin
                            // Auto bit stays clear: saving happens only on command
                            next_reply.data = is_store ? `CAP_STORE : `CAP_RESTORE; // R13 R19 R21
                        end
                    end else begin
                        next_reply.data = `ABORT_NOSUB; // R21
                    end
                end else begin
                    next_reply.data = `ABORT_NOOBJ;
                end
            end
            default: begin
                next_reply.data = `ABORT_BADCMD;
            end
        endcase
    end

    // Only one operation in flight; new requests wait on rx_ready
    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (accept) begin
                    next_state = start_op ? st_wait : st_reply; // R22
                end
            end
            st_wait: begin
                if (nvm_done) begin
                    next_state = st_reply; // R8
                end
            end
            st_reply: begin
                if (tx_ready) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state    <= st_idle;
            rx_ready <= 1'b0;
            tx_valid <= 1'b0;
        end else begin
            state    <= next_state;
            rx_ready <= (next_state == st_idle); // R22
            tx_valid <= (next_state == st_reply);
        end
    end

    // Reply word; store and restore confirm only after the engine is done
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_frame <= '0;
            pend_hdr <= '0;
        end else if (state == st_idle && accept) begin
            tx_frame <= next_reply;
            pend_hdr <= next_reply;
        end else if (state == st_wait && nvm_done) begin
            tx_frame.index <= pend_hdr.index;
            tx_frame.sub   <= pend_hdr.sub;
            if (nvm_fail) begin
                tx_frame.cmd  <= `RSP_ABORT;
                tx_frame.data <= `ABORT_FAIL; // R9
            end else begin
                tx_frame.cmd  <= `RSP_DOWNLOAD; // R8 R17
                tx_frame.data <= 32'h00000000;
            end
        end
    end

    // Request to the non-volatile engine, one-cycle pulse
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nvm_req <= 1'b0;
            nvm_cmd <= '0;
        end else begin
            nvm_req <= (state == st_idle) && accept && start_op;
            if ((state == st_idle) && accept && start_op) begin
                nvm_cmd.restore    <= !is_store;
                nvm_cmd.from_saved <= use_saved_config; // R15
                nvm_cmd.sub        <= rx_frame.sub;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            life_factor <= `FACTOR_RESET;
        end else if ((state == st_idle) && accept && write_factor) begin
            life_factor <= rx_frame.data[7:0]; // R1
        end
    end

    // Registered product keeps the multiplier off the output path
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            life_time        <= 24'h000000;
            guarding_enabled <= 1'b0;
        end else begin
            life_time        <= 24'(life_factor) * 24'(guard_time); // R1 R3
            guarding_enabled <= (life_factor != 8'h00) && (guard_time != 16'h0000); // R2 R3
        end
    end

    // Set wins over software clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            warn_msg           <= 1'b0;
            warn_store_refused <= 1'b0;
        end else begin
            warn_msg <= (state == st_idle) && accept && refuse_state; // R6
            if ((state == st_idle) && accept && refuse_state) begin
                warn_store_refused <= 1'b1; // R6
            end else if (warn_clear) begin
                warn_store_refused <= 1'b0;
            end
        end
    end

    // New values wait for the matching NMT reset; set wins over clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reset_node_pending <= 1'b0;
            reset_comm_pending <= 1'b0;
        end else begin
            if (state == st_wait && nvm_done && !nvm_fail && pend_hdr.sub != 8'h02) begin
                reset_node_pending <= 1'b1; // R18
            end else if (nmt_reset_node) begin
                reset_node_pending <= 1'b0;
            end
            if (state == st_wait && nvm_done && !nvm_fail && pend_hdr.sub == 8'h02) begin
                reset_comm_pending <= 1'b1; // R18
            end else if (nmt_reset_comm || nmt_reset_node) begin
                reset_comm_pending <= 1'b0;
            end
        end
    end

    chk_life_product: assert property (@(posedge clock) disable iff (rst) // R1
        ##1 life_time == 24'($past(life_factor)) * 24'($past(guard_time)))
        else $error("life time not factor times guard time");

    chk_guard_off: assert property (@(posedge clock) disable iff (rst) // R2
        (life_factor == 8'h00) |=> !guarding_enabled)
        else $error("guarding on with zero factor");

    chk_guard_zero: assert property (@(posedge clock) disable iff (rst) // R3
        (guard_time == 16'h0000) |=> !guarding_enabled)
        else $error("guarding on with zero guard time");

    chk_sub0_read: assert property (@(posedge clock) disable iff (rst) // R4
        (accept && rx_frame.cmd == `CMD_UPLOAD && rx_frame.index == `IDX_STORE && rx_frame.sub == 8'h00)
        |=> tx_valid && tx_frame.data == 32'h00000005)
        else $error("highest sub-index not five");

    chk_state_refuse: assert property (@(posedge clock) disable iff (rst) // R6
        (nvm_req && !nvm_cmd.restore) |-> !$past(drive_op_enabled) && !$past(drive_quick_stop))
        else $error("store started in enabled state");

    chk_refuse_warn: assert property (@(posedge clock) disable iff (rst) // R6
        (accept && refuse_state) |=> warn_msg && warn_store_refused && tx_frame.cmd == `RSP_ABORT)
        else $error("refused store without warning");

    chk_save_sig: assert property (@(posedge clock) disable iff (rst) // R7
        (nvm_req && !nvm_cmd.restore) |-> $past(rx_frame.data) == `SIG_SAVE)
        else $error("store without save signature");

    chk_load_sig: assert property (@(posedge clock) disable iff (rst) // R16
        (nvm_req && nvm_cmd.restore) |-> $past(rx_frame.data) == `SIG_LOAD && nvm_cmd.sub == 8'h01)
        else $error("restore without load signature");

    chk_confirm_late: assert property (@(posedge clock) disable iff (rst) // R8
        (nvm_req ##1 (!nvm_done)[*2]) |-> !tx_valid)
        else $error("confirmation before operation done");

    chk_fail_code: assert property (@(posedge clock) disable iff (rst) // R9
        (state == st_wait && nvm_done && nvm_fail) |=> tx_valid && tx_frame.data == `ABORT_FAIL)
        else $error("failed operation not aborted");

    chk_bad_sig: assert property (@(posedge clock) disable iff (rst) // R10
        (accept && rx_frame.cmd == `CMD_DOWNLOAD && rx_frame.index == `IDX_STORE
         && rx_frame.sub == 8'h01 && rx_frame.data != `SIG_SAVE)
        |=> tx_valid && tx_frame.data == `ABORT_SIG && !nvm_req)
        else $error("wrong signature not aborted");

    chk_dc_link: assert property (@(posedge clock) disable iff (rst) // R11
        (nvm_req && !nvm_cmd.restore) |-> $past(dc_link_present))
        else $error("store without DC-link");

    chk_store_cap: assert property (@(posedge clock) disable iff (rst) // R13
        (accept && rx_frame.cmd == `CMD_UPLOAD && rx_frame.index == `IDX_STORE && rx_frame.sub == 8'h01)
        |=> tx_frame.data == 32'h00000001)
        else $error("store capability word wrong");

    chk_one_op: assert property (@(posedge clock) disable iff (rst) // R22
        nvm_req |-> !rx_ready ##1 !nvm_req)
        else $error("second operation while busy");

    chk_factor_write: assert property (@(posedge clock) disable iff (rst) // R1
        (accept && rx_frame.cmd == `CMD_DOWNLOAD && rx_frame.index == `IDX_LIFE && rx_frame.sub == 8'h00)
        |=> life_factor == $past(rx_frame.data[7:0]))
        else $error("life time factor not written");

    chk_guard_on: assert property (@(posedge clock) disable iff (rst) // R2
        (life_factor != 8'h00 && guard_time != 16'h0000) |=> guarding_enabled)
        else $error("guarding off with both values set");

    chk_store_sub: assert property (@(posedge clock) disable iff (rst) // R5
        (accept && rx_frame.cmd == `CMD_DOWNLOAD && rx_frame.index == `IDX_STORE
         && (rx_frame.sub == 8'h00 || rx_frame.sub > `SUB_LAST_STORE)) |=> tx_frame.data == `ABORT_NOSUB && !nvm_req)
        else $error("unsupported store sub-index taken");

    chk_dc_refuse: assert property (@(posedge clock) disable iff (rst) // R11
        (accept && rx_frame.cmd == `CMD_DOWNLOAD && rx_frame.index == `IDX_STORE && !dc_link_present)
        |=> tx_frame.cmd == `RSP_ABORT && !nvm_req)
        else $error("store accepted without DC-link");

    chk_restore_cap: assert property (@(posedge clock) disable iff (rst) // R19
        (accept && rx_frame.cmd == `CMD_UPLOAD && rx_frame.index == `IDX_RESTORE && rx_frame.sub == 8'h01)
        |=> tx_frame.data == 32'h00000001)
        else $error("restore capability word wrong");

    chk_restore_sub: assert property (@(posedge clock) disable iff (rst) // R14
        (accept && rx_frame.cmd == `CMD_DOWNLOAD && rx_frame.index == `IDX_RESTORE && rx_frame.sub != 8'h01)
        |=> tx_frame.cmd == `RSP_ABORT && !nvm_req)
        else $error("unavailable restore sub-index taken");

    chk_restore_src: assert property (@(posedge clock) disable iff (rst) // R15
        (nvm_req && nvm_cmd.restore) |-> nvm_cmd.from_saved == $past(use_saved_config))
        else $error("restore source not passed on");

    chk_op_confirm: assert property (@(posedge clock) disable iff (rst) // R8 R17
        (state == st_wait && nvm_done && !nvm_fail) |=> tx_valid && tx_frame.cmd == `RSP_DOWNLOAD
        && tx_frame.data == 32'h00000000)
        else $error("completed operation not confirmed");

    chk_pending_set: assert property (@(posedge clock) disable iff (rst) // R18
        (state == st_wait && nvm_done && !nvm_fail) |=> reset_node_pending || reset_comm_pending)
        else $error("no reset pending after operation");

    chk_reply_hold: assert property (@(posedge clock) disable iff (rst) // R17
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_frame))
        else $error("reply dropped before taken");
endmodule

//--- bench/sdo_master_model.sv
// Behavioural network master issuing expedited SDO requests one at a time
module sdo_master_model (
    input  wire logic                        clock,
    output param_guard_pkg::sdo_frame_s      rx_frame,
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    input  wire param_guard_pkg::sdo_frame_s tx_frame,
    input  wire logic                        tx_valid,
    output logic                             tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import param_guard_pkg::*;

    initial begin
        rx_frame = '0;
        rx_valid = 0;
        tx_ready = 1;
    end

    // Stall holds off the reply sink for that many cycles
    task automatic xfer(input sdo_frame_s req, input int stall, output sdo_frame_s rsp, output logic ok,
                        output time at);
        int n;
        n = 0;
        @(posedge clock);
        #1 rx_frame = req;
        rx_valid = 1;
        tx_ready = (stall == 0);
        @(negedge clock);
        while (rx_ready !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        #1 rx_valid = 0;
        // Released lines must not keep showing a stale frame
        rx_frame = ~req;
        while (tx_valid !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        repeat (stall) @(negedge clock);
        rsp = tx_frame;
        at = $time;
        ok = (n < 400) && (tx_valid === 1'b1);
        if (stall > 0) begin
            @(posedge clock);
            #1 tx_ready = 1;
        end
        @(posedge clock);
    endtask
endmodule

//--- bench/param_store_restore_guard_test.sv
// Self-checking bench for the parameter store guard
module param_store_restore_guard_test;
    timeunit 1ns;
    timeprecision 1ps;
    import param_guard_pkg::*;

    logic        clock, rst, rx_valid, rx_ready, tx_valid, tx_ready, guarding_enabled, drive_op_enabled;
    logic        drive_quick_stop, dc_link_present, use_saved_config, nvm_req, nvm_done, nvm_fail, warn_msg;
    logic        warn_store_refused, warn_clear, reset_node_pending, reset_comm_pending, nmt_reset_node;
    logic        nmt_reset_comm, fail_mode;
    logic [15:0] guard_time;
    logic [7:0]  life_factor;
    logic [23:0] life_time;
    sdo_frame_s  rx_frame, tx_frame;
    nvm_cmd_s    nvm_cmd, last_cmd;
    int          failures, checks, nreq, nwarn, stall, n0;
    time         done_at;

    param_store_restore_guard param_store_restore_guard_i (.clock, .rst, .rx_frame, .rx_valid, .rx_ready,
        .tx_frame, .tx_valid, .tx_ready, .guard_time, .life_factor, .life_time, .guarding_enabled,
        .drive_op_enabled, .drive_quick_stop, .dc_link_present, .use_saved_config, .nvm_req, .nvm_cmd,
        .nvm_done, .nvm_fail, .warn_msg, .warn_store_refused, .warn_clear, .reset_node_pending,
        .reset_comm_pending, .nmt_reset_node, .nmt_reset_comm);
    sdo_master_model sdo_master_model_i (.clock, .rx_frame, .rx_valid, .rx_ready, .tx_frame, .tx_valid,
        .tx_ready);

    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic req(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] data, input logic [7:0] ecmd, input logic [31:0] edata);
        sdo_frame_s rsp;
        logic       ok;
        time        at;
        sdo_master_model_i.xfer({data, sub, idx, cmd}, stall, rsp, ok, at);
        if (ok !== 1'b1) begin
            check("reply timeout", 0, 1);
            end_of_test();
        end else begin
            check("reply cmd", rsp.cmd, ecmd);
            check("reply data", rsp.data, edata);
            check("reply index", rsp.index, idx);
            check("reply sub", rsp.sub, sub);
            if (ecmd == 8'h60 && idx != 16'h100d)
                check("reply after store", at > done_at, 1);
        end
    endtask

    // Storage engine: answers three cycles after each start pulse
    initial begin
        nvm_done = 0;
        nvm_fail = 1;
        forever begin
            tick(1);
            if (nvm_req === 1'b1) begin
                nreq++;
                last_cmd = nvm_cmd;
                // Stale time from an earlier op must not let an early reply pass
                done_at = '1;
                check("busy rx_ready", rx_ready, 0);
                tick(3);
                nvm_done = 1;
                nvm_fail = fail_mode;
                done_at = $time;
                tick(1);
                nvm_done = 0;
                nvm_fail = ~fail_mode;
            end
        end
    end

    always @(negedge clock)
        if (warn_msg === 1'b1)
            nwarn++;

    initial begin
        rst = 1;
        guard_time = 16'h0064;
        {drive_op_enabled, drive_quick_stop, use_saved_config, warn_clear} = 4'h0;
        {nmt_reset_node, nmt_reset_comm, fail_mode} = 3'h0;
        dc_link_present = 1;
        stall = 0;
        tick(8);
        rst = 0;
        check("life_factor", life_factor, 0);
        check("guarding_enabled", guarding_enabled, 0);
        req(8'h40, 16'h100d, 0, 0, 8'h4f, 0);
        req(8'h23, 16'h100d, 0, 32'hffffff0a, 8'h60, 0);
        req(8'h40, 16'h100d, 0, 0, 8'h4f, 32'h0a);
        tick(2);
        check("life_time", life_time, 24'd1000);
        check("guarding_enabled", guarding_enabled, 1);
        guard_time = 0;
        tick(2);
        check("guarding_enabled", guarding_enabled, 0);
        guard_time = 16'h0064;
        req(8'h23, 16'h100d, 0, 32'hff, 8'h60, 0);
        tick(2);
        check("life_time", life_time, 24'd25500);
        req(8'h23, 16'h100d, 0, 0, 8'h60, 0);
        tick(2);
        check("guarding_enabled", guarding_enabled, 0);
        for (int s = 0; s < 6; s++) begin
            req(8'h40, 16'h1010, s[7:0], 0, s == 0 ? 8'h4f : 8'h43, s == 0 ? 5 : (s < 5 ? 1 : 0));
            req(8'h40, 16'h1011, s[7:0], 0, s == 0 ? 8'h4f : 8'h43, s == 0 ? 5 : (s == 1 ? 1 : 0));
        end
        req(8'h40, 16'h1010, 8'h06, 0, 8'h80, 32'h06090011);
        for (int s = 1; s < 5; s++) begin
            stall = s % 2 * 3;
            req(8'h23, 16'h1010, s[7:0], 32'h65766173, 8'h60, 0);
            check("store sub", last_cmd.sub, s[7:0]);
            check("store kind", last_cmd.restore, 0);
        end
        stall = 0;
        tick(1);
        check("node pending", reset_node_pending, 1);
        check("comm pending", reset_comm_pending, 1);
        nmt_reset_node = 1;
        tick(1);
        nmt_reset_node = 0;
        tick(1);
        check("node pending", reset_node_pending, 0);
        check("comm pending", reset_comm_pending, 0);
        n0 = nreq;
        req(8'h23, 16'h1010, 1, 32'h64616f6c, 8'h80, 32'h08000002);
        req(8'h23, 16'h1010, 1, 32'h65766172, 8'h80, 32'h08000002);
        req(8'h23, 16'h1010, 5, 32'h65766173, 8'h80, 32'h06090011);
        req(8'h23, 16'h1010, 0, 32'h65766173, 8'h80, 32'h06090011);
        req(8'h23, 16'h1011, 2, 32'h64616f6c, 8'h80, 32'h06090011);
        req(8'h23, 16'h1011, 1, 32'h65766173, 8'h80, 32'h08000002);
        check("no store started", nreq, n0);
        for (int m = 0; m < 3; m++) begin
            tick(1);
            drive_op_enabled = (m == 0);
            drive_quick_stop = (m == 1);
            dc_link_present = (m != 2);
            req(8'h23, 16'h1010, 1, 32'h65766173, 8'h80, 32'h08000022);
            tick(1);
            check("store warning", warn_store_refused, m < 2);
            warn_clear = 1;
            tick(1);
            warn_clear = 0;
        end
        check("warn pulses", nwarn, 2);
        check("no store started", nreq, n0);
        {drive_op_enabled, drive_quick_stop, dc_link_present, fail_mode} = 4'h3;
        req(8'h23, 16'h1010, 1, 32'h65766173, 8'h80, 32'h06060000);
        req(8'h23, 16'h1011, 1, 32'h64616f6c, 8'h80, 32'h06060000);
        tick(1);
        fail_mode = 0;
        use_saved_config = 1;
        check("node pending", reset_node_pending, 0);
        req(8'h23, 16'h1011, 1, 32'h64616f6c, 8'h60, 0);
        check("restore kind", last_cmd.restore, 1);
        check("restore source", last_cmd.from_saved, 1);
        tick(1);
        check("node pending", reset_node_pending, 1);
        nmt_reset_comm = 1;
        tick(1);
        nmt_reset_comm = 0;
        tick(1);
        check("node pending", reset_node_pending, 1);
        check("comm pending", reset_comm_pending, 0);
        nmt_reset_node = 1;
        tick(1);
        nmt_reset_node = 0;
        tick(1);
        check("node pending", reset_node_pending, 0);
        end_of_test();
    end
endmodule
